// ### common/prf_defines.svh
`ifndef PRF_DEFINES_SVH
`define PRF_DEFINES_SVH
// ----------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------
`define PRF_OFS_ASYNC_LOW_SET   12'h108
`define PRF_OFS_ASYNC_LOW_CLR   12'h10C
`define PRF_OFS_HIGH_SET        12'h110
`define PRF_OFS_HIGH_CLR        12'h114
`define PRF_OFS_LOW_SET         12'h118
`define PRF_OFS_LOW_CLR         12'h11C
`define PRF_OFS_UPPER_BOUND     12'h120
`define PRF_OFS_ASYNC_HIGH_SET  12'h100
`define PRF_OFS_ASYNC_HIGH_CLR  12'h104
`define PRF_OFS_BUS_ID          12'h124
`define PRF_ADDR_BITS           12
// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define PRF_ALL_BUS_BIT         31
`define PRF_HIGH_NODE_BASE      6'h20
`define PRF_BCAST_HI_IDX        6'h1F
`define PRF_LOCAL_BUS_ID        10'h3FF
`define PRF_ZERO_WORD           32'h0000_0000
`define PRF_HIGH_NODE_MASK      32'h7FFF_FFFF
`define PRF_TRANS_NONSEQ        2'h2
`define PRF_TRANS_SEQ           2'h3
`endif

// ### common/prf_pkg.sv
package prf_pkg;
  // request seen at the receiver: source bus and node
  typedef struct packed {
    logic       valid;
    logic [9:0] src_bus;
    logic [5:0] src_node;
    logic       to_phys;
  } prf_req_type;

  // routing decision for the request
  typedef struct packed {
    logic valid;
    logic to_phys_ctx;
    logic to_async_ctx;
    logic drop;
  } prf_route_type;
endpackage

// ### rtl/prf_route.sv
`timescale 1ns/1ps
`include "prf_defines.svh"
// route decision from the filter words; registered by the caller
module prf_route (
  input  prf_pkg::prf_req_type   req,
  input  wire logic [31:0]       async_high,
  input  wire logic [31:0]       async_low,
  input  wire logic [31:0]       phys_high,
  input  wire logic [31:0]       phys_low,
  input  wire logic [9:0]        local_bus,
  output prf_pkg::prf_route_type route
);
  import prf_pkg::*;

  logic local_src;
  logic async_ok;
  logic phys_ok;
  logic [5:0] hi_idx;

  // -----------------------------------------------------------------
  // filter lookup
  // -----------------------------------------------------------------
  always_comb begin
    hi_idx    = req.src_node - `PRF_HIGH_NODE_BASE;
    local_src = (req.src_bus == local_bus) || (req.src_bus == `PRF_LOCAL_BUS_ID);
    // node 63 is broadcast and has no enable bit
    if (req.src_node[5]) begin
      async_ok = (hi_idx != `PRF_BCAST_HI_IDX) && async_high[hi_idx[4:0]];
      phys_ok  = (hi_idx != `PRF_BCAST_HI_IDX) && phys_high[hi_idx[4:0]];
    end else begin
      async_ok = async_low[req.src_node[4:0]];
      phys_ok  = phys_low[req.src_node[4:0]];
    end
    // remote buses skip the per-node compare
    if (!local_src) begin
      async_ok = phys_high[`PRF_ALL_BUS_BIT];
      phys_ok  = phys_high[`PRF_ALL_BUS_BIT];
    end
  end

  // -----------------------------------------------------------------
  // decision: async filter first, then the physical one
  // -----------------------------------------------------------------
  always_comb begin
    route.valid        = req.valid;
    route.drop         = req.valid && !async_ok;
    route.to_phys_ctx  = req.valid && async_ok && req.to_phys && phys_ok;
    route.to_async_ctx = req.valid && async_ok && !(req.to_phys && phys_ok);
  end
endmodule

// ### rtl/prf_filter.sv
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "prf_defines.svh"
// Contract
// - upper word bit k, for k 0 to 30, enables physical handling for node k plus 32
// - lower word bit k enables physical handling for node k
// - physical-bound packets pass the async filter, then the physical filter
// - cleared physical bit sends the request to the async receive context
// - lower word set at 118h, clear at 11Ch, resets to zero
// - upper bound at 120h reads zero, writes ignored
// - lower word covers only the low node numbers
// - upper word set at 110h, clear at 114h, read/set/clear
// - upper bit 31 accepts remote buses, survives host bus reset
// - per-node compare only for local bus; remote needs bit 31
module prf_filter (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic [31:0]            hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic              host_bus_reset,
  input  prf_pkg::prf_req_type   rx_req,
  output prf_pkg::prf_route_type rx_route,
  output logic [31:0]            phys_low_q,
  output logic [31:0]            phys_high_q
);
  import prf_pkg::*;

  logic [31:0] async_low_q;
  logic [31:0] async_high_q;
  logic [9:0]  bus_id_q;
  logic        wr_pend_q;
  logic [`PRF_ADDR_BITS-1:0] wr_addr_q;
  logic        take;
  logic [`PRF_ADDR_BITS-1:0] a;
  logic [31:0] rd_d;
  prf_req_type   req_q;
  prf_route_type route_c;
  logic        hbr_s1_q;
  logic        hbr_s2_q;

  // -----------------------------------------------------------------
  // bus address phase
  // -----------------------------------------------------------------
  assign take = hsel && hready &&
                (htrans == `PRF_TRANS_NONSEQ || htrans == `PRF_TRANS_SEQ);
  assign a    = haddr[`PRF_ADDR_BITS-1:0];

  // hsize unused: only whole-word transfers are supported
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
    end else begin
      wr_pend_q <= take && hwrite;
      if (take) begin
        wr_addr_q <= a;
      end
    end
  end

  // zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // read mux, registered at the address phase
  // -----------------------------------------------------------------
  always_comb begin
    unique case (a)
      `PRF_OFS_HIGH_SET, `PRF_OFS_HIGH_CLR:             rd_d = phys_high_q;
      `PRF_OFS_LOW_SET, `PRF_OFS_LOW_CLR:               rd_d = phys_low_q;
      `PRF_OFS_ASYNC_HIGH_SET, `PRF_OFS_ASYNC_HIGH_CLR: rd_d = async_high_q;
      `PRF_OFS_ASYNC_LOW_SET, `PRF_OFS_ASYNC_LOW_CLR:   rd_d = async_low_q;
      `PRF_OFS_BUS_ID:                                  rd_d = {22'h0, bus_id_q};
      `PRF_OFS_UPPER_BOUND:                             rd_d = `PRF_ZERO_WORD;
      default:                                          rd_d = `PRF_ZERO_WORD;
    endcase
  end

  // a write just before a read of the same word is not bypassed; the read returns the old value:
  // the register updates at the edge that ends the write data phase, the same edge that samples the read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= `PRF_ZERO_WORD;
    end else if (take && !hwrite) begin
      hrdata <= rd_d;
    end
  end

  // -----------------------------------------------------------------
  // host bus reset synchroniser
  // -----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hbr_s1_q <= 1'b0;
      hbr_s2_q <= 1'b0;
    end else begin
      hbr_s1_q <= host_bus_reset;
      hbr_s2_q <= hbr_s1_q;
    end
  end

  // -----------------------------------------------------------------
  // physical filter words, set/clear ports
  // -----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phys_low_q <= `PRF_ZERO_WORD;
    end else if (hbr_s2_q) begin
      phys_low_q <= `PRF_ZERO_WORD;
    end else if (wr_pend_q && wr_addr_q == `PRF_OFS_LOW_SET) begin
      phys_low_q <= phys_low_q | hwdata;
    end else if (wr_pend_q && wr_addr_q == `PRF_OFS_LOW_CLR) begin
      phys_low_q <= phys_low_q & ~hwdata;
    end
  end

  // bit 31 keeps its value over a host bus reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phys_high_q <= `PRF_ZERO_WORD;
    end else if (hbr_s2_q) begin
      phys_high_q <= phys_high_q & ~`PRF_HIGH_NODE_MASK;
    end else if (wr_pend_q && wr_addr_q == `PRF_OFS_HIGH_SET) begin
      phys_high_q <= phys_high_q | hwdata;
    end else if (wr_pend_q && wr_addr_q == `PRF_OFS_HIGH_CLR) begin
      phys_high_q <= phys_high_q & ~hwdata;
    end
  end

  // -----------------------------------------------------------------
  // async filter words and local bus number
  // -----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      async_low_q  <= `PRF_ZERO_WORD;
      async_high_q <= `PRF_ZERO_WORD;
    end else if (hbr_s2_q) begin
      async_low_q  <= `PRF_ZERO_WORD;
      async_high_q <= `PRF_ZERO_WORD;
    end else if (wr_pend_q) begin
      if (wr_addr_q == `PRF_OFS_ASYNC_LOW_SET) begin
        async_low_q <= async_low_q | hwdata;
      end
      if (wr_addr_q == `PRF_OFS_ASYNC_LOW_CLR) begin
        async_low_q <= async_low_q & ~hwdata;
      end
      if (wr_addr_q == `PRF_OFS_ASYNC_HIGH_SET) begin
        async_high_q <= async_high_q | hwdata;
      end
      if (wr_addr_q == `PRF_OFS_ASYNC_HIGH_CLR) begin
        async_high_q <= async_high_q & ~hwdata;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_id_q <= `PRF_LOCAL_BUS_ID;
    end else if (wr_pend_q && wr_addr_q == `PRF_OFS_BUS_ID) begin
      bus_id_q <= hwdata[9:0];
    end
  end

  // -----------------------------------------------------------------
  // request routing: capture, decide, register result
  // -----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_q <= '0;
    end else begin
      req_q <= rx_req;
    end
  end

  prf_route u_route (
    .req        (req_q),
    .async_high (async_high_q),
    .async_low  (async_low_q),
    .phys_high  (phys_high_q),
    .phys_low   (phys_low_q),
    .local_bus  (bus_id_q),
    .route      (route_c)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_route <= '0;
    end else begin
      rx_route <= route_c;
    end
  end
endmodule

// ### testbench/prf_filter_sva.sv
`timescale 1ns/1ps
module prf_filter_sva (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hreadyout,
  input  wire logic              hresp,
  input  wire logic              host_bus_reset,
  input  prf_pkg::prf_req_type   rx_req,
  input  prf_pkg::prf_route_type rx_route,
  input  wire logic [31:0]       phys_low_q,
  input  wire logic [31:0]       phys_high_q
);
  import prf_pkg::*;
  // ----------------------------------------
  // port checks, one clock domain
  // ----------------------------------------
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  a_ready_high: assert property (hreadyout == 1'b1)
    else $error("slave inserted a wait state");
  a_route_follows: assert property (rx_req.valid |-> ##2 rx_route.valid)
    else $error("request got no route two edges later");
  a_route_cause: assert property (rx_route.valid |-> $past(rx_req.valid, 2))
    else $error("route without a request");
  a_route_onehot: assert property (rx_route.valid |->
    $onehot({rx_route.to_phys_ctx, rx_route.to_async_ctx, rx_route.drop}))
    else $error("route decision not exactly one target");
  a_phys_needs_req: assert property (rx_route.to_phys_ctx |-> $past(rx_req.to_phys, 2))
    else $error("physical context for a non physical request");
  // filter held steady so the decision cannot hinge on a write in flight
  a_low_bit_off: assert property ((rx_req.valid && rx_req.src_bus == 10'h3FF
    && !rx_req.src_node[5] && !phys_low_q[rx_req.src_node[4:0]]) ##1 $stable(phys_low_q)
    |-> ##1 !rx_route.to_phys_ctx) else $error("cleared low bit still routed physical");
  a_hbr_clears: assert property (host_bus_reset [*4] |->
    phys_low_q == 32'h0 && phys_high_q[30:0] == 31'h0)
    else $error("host bus reset left filter bits set");

  c_phys: cover property (rx_route.valid && rx_route.to_phys_ctx);
  c_async: cover property (rx_route.valid && rx_route.to_async_ctx);
  c_drop: cover property (rx_route.valid && rx_route.drop);
  c_hbr: cover property (host_bus_reset [*4]);
endmodule

bind prf_filter prf_filter_sva i_prf_filter_sva (.hclk(hclk), .hresetn(hresetn),
  .hreadyout(hreadyout), .hresp(hresp), .host_bus_reset(host_bus_reset), .rx_req(rx_req),
  .rx_route(rx_route), .phys_low_q(phys_low_q), .phys_high_q(phys_high_q));

// ### testbench/prf_node_model.sv
`timescale 1ns/1ps
module prf_node_model (
  input  wire logic            hclk,
  output prf_pkg::prf_req_type rx_req
);
  import prf_pkg::*;
  initial rx_req = '0;
  // one frame for one cycle; idle fields scrambled so stale values never match
  task automatic send(input logic [9:0] bus, input logic [5:0] node, input logic phys);
    @(posedge hclk);
    rx_req <= '{1'b1, bus, node, phys};
    @(posedge hclk);
    rx_req <= '{1'b0, ~bus, ~node, ~phys};
  endtask
endmodule

// ### testbench/tb_prf_filter.sv
`timescale 1ns/1ps
`include "prf_defines.svh"
module tb_prf_filter;
  import prf_pkg::*;
  logic          hclk;
  logic          hresetn;
  logic          hsel;
  logic [31:0]   haddr;
  logic [1:0]    htrans;
  logic          hwrite;
  logic [31:0]   hwdata;
  logic [31:0]   hrdata;
  logic          hreadyout;
  logic          hresp;
  logic          host_bus_reset;
  prf_req_type   rx_req;
  prf_route_type rx_route;
  logic [31:0]   rd;
  int            n_errors;
  int            checks_done;

  prf_filter i_prf_filter (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .host_bus_reset(host_bus_reset),
    .rx_req(rx_req), .rx_route(rx_route), .phys_low_q(), .phys_high_q());
  prf_node_model i_prf_node_model (.hclk(hclk), .rx_req(rx_req));

  // ----------------------------------------
  // clock, tasks
  // ----------------------------------------
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  task automatic stop_test();
    $display("mismatches %0d of %0d checks", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      n_errors++;
    end
  endtask

  // bounded wait for hready at an edge; a stuck slave ends the run
  task automatic wait_rdy();
    int i;
    i = 0;
    do begin
      @(posedge hclk);
      i++;
    end while (hreadyout !== 1'b1 && i < 16);
    if (hreadyout !== 1'b1) begin
      n_errors++;
      stop_test();
    end
  endtask

  // single word transfer; idle edge after it so a read never sees a write in flight
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
    @(posedge hclk);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic rt(input logic [9:0] b, input logic [5:0] n, input logic p,
                    input logic [3:0] e);
    i_prf_node_model.send(b, n, p);
    @(posedge hclk);
    #1;
    chk({28'h0, rx_route}, {28'h0, e});
  endtask

  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (5000) @(posedge hclk);
    n_errors++;
    stop_test();
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    host_bus_reset = 1'b0;
    n_errors = 0;
    checks_done = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk(`PRF_OFS_LOW_SET, 32'h0);
    rd_chk(`PRF_OFS_HIGH_CLR, 32'h0);
    xfer(1'b1, `PRF_OFS_LOW_SET, 32'hA5A5_0001);
    xfer(1'b1, `PRF_OFS_LOW_SET, 32'h0);
    rd_chk(`PRF_OFS_LOW_CLR, 32'hA5A5_0001);
    xfer(1'b1, `PRF_OFS_LOW_CLR, 32'h0000_0001);
    rd_chk(`PRF_OFS_LOW_SET, 32'hA5A5_0000);
    xfer(1'b1, `PRF_OFS_UPPER_BOUND, 32'hFFFF_FFFF);
    rd_chk(`PRF_OFS_UPPER_BOUND, 32'h0);
    rd_chk(12'h200, 32'h0);
    xfer(1'b1, `PRF_OFS_HIGH_SET, 32'h8000_0004);
    rd_chk(`PRF_OFS_HIGH_CLR, 32'h8000_0004);
    // async filter open except node 5 and broadcast node 63, so the physical bits decide the rest
    xfer(1'b1, `PRF_OFS_ASYNC_LOW_SET, 32'hFFFF_FFDF);
    xfer(1'b1, `PRF_OFS_ASYNC_HIGH_SET, 32'hFFFF_FFFF);
    rt(10'h3FF, 6'd16, 1'b1, 4'b1100);
    rt(10'h3FF, 6'd0, 1'b1, 4'b1010);
    rt(10'h3FF, 6'd16, 1'b0, 4'b1010);
    rt(10'h3FF, 6'd34, 1'b1, 4'b1100);
    rt(10'h3FF, 6'd50, 1'b1, 4'b1010);
    rt(10'h3FF, 6'd48, 1'b1, 4'b1010);
    rt(10'h3FF, 6'd5, 1'b1, 4'b1001);
    rt(10'h3FF, 6'd63, 1'b1, 4'b1001);
    rt(10'h001, 6'd0, 1'b1, 4'b1100);
    // bus 1 becomes the local bus: node 0 now goes through the per-node compare
    xfer(1'b1, `PRF_OFS_BUS_ID, 32'h0000_0001);
    rd_chk(`PRF_OFS_BUS_ID, 32'h0000_0001);
    rt(10'h001, 6'd0, 1'b1, 4'b1010);
    // async filter clear ports: a cleared async bit drops before the physical check
    xfer(1'b1, `PRF_OFS_ASYNC_HIGH_CLR, 32'h0000_0004);
    rd_chk(`PRF_OFS_ASYNC_HIGH_SET, 32'hFFFF_FFFB);
    rt(10'h3FF, 6'd34, 1'b1, 4'b1001);
    xfer(1'b1, `PRF_OFS_ASYNC_LOW_CLR, 32'h0001_0000);
    rd_chk(`PRF_OFS_ASYNC_LOW_SET, 32'hFFFE_FFDF);
    rt(10'h3FF, 6'd16, 1'b1, 4'b1001);
    xfer(1'b1, `PRF_OFS_LOW_SET, 32'h0000_00FF);
    host_bus_reset <= 1'b1;
    repeat (6) @(posedge hclk);
    host_bus_reset <= 1'b0;
    repeat (3) @(posedge hclk);
    rd_chk(`PRF_OFS_LOW_SET, 32'h0);
    rd_chk(`PRF_OFS_HIGH_SET, 32'h8000_0000);
    xfer(1'b1, `PRF_OFS_HIGH_CLR, 32'h8000_0000);
    // bus 2 is remote while the local bus number is 1
    rt(10'h002, 6'd0, 1'b1, 4'b1001);
    stop_test();
  end
endmodule
